// ---- src/fc_pkg.sv ----
// Opcodes, field positions and link phases of the serial flash command decoder
// Operation
// - Select falling edge starts; first byte opcode
// - Single line: rising edge sample, MSB first
// - Four-line mode: every byte two clocks
// - Four-line mode: upper nibble first
// - Select rising edge closes the command
// - Reads may end after any bit
// - Writes need whole bytes, else dropped
// - While busy only status reads, suspend; array reads, and FFh or the 66h/99h pair (mode exit only) in four-line mode, are still taken
// - 05h/35h/15h/33h repeat one status byte
// - 06h sets, 04h clears latch; 50h volatile
// - 01h writes up to three; 31h, 11h one
// - 77h: three skipped bytes, wrap bits 6:4
// - 02h/32h: three address bytes, then data
// - 20h/52h/D8h take address; C7h/60h whole
// - 03h no dummy; 0Bh/3Bh/6Bh one dummy byte
// - Returned bytes leave MSB first
// - Dual output: line one carries odd bits
package fc_pkg;
  localparam logic [7:0] OP_STAT_RD1 = 8'h05;
  localparam logic [7:0] OP_STAT_RD2 = 8'h35;
  localparam logic [7:0] OP_STAT_RD3 = 8'h15;
  localparam logic [7:0] OP_STAT_RD3B = 8'h33;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_VOL_EN = 8'h50;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_STAT_WR1 = 8'h01;
  localparam logic [7:0] OP_STAT_WR2 = 8'h31;
  localparam logic [7:0] OP_STAT_WR3 = 8'h11;
  localparam logic [7:0] OP_WRAP_SET = 8'h77;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_CHIP_ER = 8'hC7;
  localparam logic [7:0] OP_CHIP_ER2 = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_FOUR_ON = 8'h38;
  localparam logic [7:0] OP_FOUR_OFF = 8'hFF;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST_DO = 8'h99;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_DREAD = 8'h3B;
  localparam logic [7:0] OP_QREAD = 8'h6B;
  localparam logic [7:0] OP_QIO_READ = 8'hEB;
  localparam logic [7:0] OP_QIO_WORD = 8'hE7;
  localparam logic [7:0] OP_QIO_OCT = 8'hE3;
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] WRAP_BYTE = 3'h3;
  localparam int unsigned WRAP_LSB = 4;
  localparam int unsigned WRAP_MSB = 6;
  localparam logic [3:0] DUMMY_BYTE_1L = 4'h8;
  localparam logic [3:0] DUMMY_BYTE_4L = 4'h2;
  localparam logic [3:0] DUMMY_QIO = 4'h4;
  localparam logic [3:0] DUMMY_WORD = 4'h2;
  localparam logic [3:0] DUMMY_OCT = 4'h0;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [2:0] WRAP_RST = 3'h0;
  typedef enum logic [2:0] {
    PH_OPC   = 3'b000,
    PH_ADDR  = 3'b001,
    PH_MODE  = 3'b011,
    PH_DUMMY = 3'b010,
    PH_DATA  = 3'b110,
    PH_SKIP  = 3'b111
  } phase_e;
endpackage

// ---- src/flash_cmd_decoder.sv ----
// Serial flash command decoder: link-clock framing and system-clock command execution
module flash_cmd_decoder (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  output logic [3:0]       io_out,
  output logic [3:0]       io_oe,
  input  wire logic        array_busy,
  input  wire logic [7:0]  rd_data,
  output logic [23:0]      rd_addr,
  output logic             cmd_valid,
  output logic [7:0]       cmd_op,
  output logic [23:0]      cmd_addr,
  output logic             data_valid,
  output logic [7:0]       data_byte,
  output logic [2:0]       wrap_cfg,
  output logic             four_line_command_mode,
  output logic             dev_reset
);
  // ----------------------------------------------------------------
  // Link domain: framing on the serial clock
  // ----------------------------------------------------------------
  fc_pkg::phase_e phase, ph_e, next_ph;
  logic        in_frame, op_ok, quad, armed_l, pd_tog;
  logic [7:0]  op, sh, next_sh;
  logic [2:0]  bcnt, bc_e, next_cnt, nbytes, opos, ow;
  logic [3:0]  dcnt, next_dc;
  logic [23:0] addr, rcnt, stat_l1, stat_l2;
  logic [7:0]  wb [4];
  logic [7:0]  pd [2];
  logic [7:0]  rd_s1, rd_s2, src, cur, osh;
  logic [1:0]  busy_l, stat_sel;
  logic        q_io_op, wide_in, byte_done, rd_op;
  logic [7:0]  status_byte_one, status_byte_two, status_byte_three;
  wire         serial_in_line = io_in[0];

  always_comb begin
    ph_e     = in_frame ? phase : fc_pkg::PH_OPC;
    bc_e     = in_frame ? bcnt : 3'h0;
    q_io_op  = op inside {fc_pkg::OP_QIO_READ, fc_pkg::OP_QIO_WORD, fc_pkg::OP_QIO_OCT};
    wide_in  = quad | (q_io_op && ph_e inside {fc_pkg::PH_ADDR, fc_pkg::PH_MODE})
             | (op == fc_pkg::OP_QPROG && ph_e == fc_pkg::PH_DATA);
    next_sh  = wide_in ? {sh[3:0], io_in} : {sh[6:0], serial_in_line};
    next_cnt = bc_e + (wide_in ? 3'h4 : 3'h1);
    byte_done = next_cnt == 3'h0;
    rd_op    = op inside {fc_pkg::OP_STAT_RD1, fc_pkg::OP_STAT_RD2, fc_pkg::OP_STAT_RD3,
                          fc_pkg::OP_STAT_RD3B, fc_pkg::OP_READ, fc_pkg::OP_FREAD,
                          fc_pkg::OP_DREAD, fc_pkg::OP_QREAD} || q_io_op;
    if (quad || q_io_op || op == fc_pkg::OP_QREAD) begin
      ow = 3'h4;
    end else if (op == fc_pkg::OP_DREAD) begin
      ow = 3'h2;
    end else begin
      ow = 3'h1;
    end
    case (op)
      fc_pkg::OP_STAT_RD1: stat_sel = 2'h1;
      fc_pkg::OP_STAT_RD2: stat_sel = 2'h2;
      fc_pkg::OP_STAT_RD3, fc_pkg::OP_STAT_RD3B: stat_sel = 2'h3;
      default: stat_sel = 2'h0;
    endcase
  end

  // Phase that follows each completed byte
  always_comb begin
    next_ph = ph_e;
    next_dc = dcnt;
    case (ph_e)
      fc_pkg::PH_OPC: begin
        case (next_sh)
          fc_pkg::OP_STAT_RD1, fc_pkg::OP_STAT_RD2, fc_pkg::OP_STAT_RD3,
          fc_pkg::OP_STAT_RD3B, fc_pkg::OP_STAT_WR1, fc_pkg::OP_STAT_WR2,
          fc_pkg::OP_STAT_WR3, fc_pkg::OP_WRAP_SET: next_ph = fc_pkg::PH_DATA;
          fc_pkg::OP_PROG, fc_pkg::OP_QPROG, fc_pkg::OP_ERASE_4K, fc_pkg::OP_ERASE_32K,
          fc_pkg::OP_ERASE_64K, fc_pkg::OP_READ, fc_pkg::OP_FREAD, fc_pkg::OP_DREAD,
          fc_pkg::OP_QREAD, fc_pkg::OP_QIO_READ, fc_pkg::OP_QIO_WORD,
          fc_pkg::OP_QIO_OCT: next_ph = fc_pkg::PH_ADDR;
          default: next_ph = fc_pkg::PH_SKIP;
        endcase
      end
      fc_pkg::PH_ADDR: begin
        if (nbytes == fc_pkg::ADDR_BYTES - 3'h1) begin
          if (q_io_op) begin
            next_ph = fc_pkg::PH_MODE;
          end else if (op inside {fc_pkg::OP_FREAD, fc_pkg::OP_DREAD, fc_pkg::OP_QREAD}) begin
            next_ph = fc_pkg::PH_DUMMY;
            next_dc = quad ? fc_pkg::DUMMY_BYTE_4L : fc_pkg::DUMMY_BYTE_1L;
          end else if (op inside {fc_pkg::OP_READ, fc_pkg::OP_PROG, fc_pkg::OP_QPROG}) begin
            next_ph = fc_pkg::PH_DATA;
          end else begin
            next_ph = fc_pkg::PH_SKIP;
          end
        end
      end
      fc_pkg::PH_MODE: begin
        case (op)
          fc_pkg::OP_QIO_READ: next_dc = fc_pkg::DUMMY_QIO;
          fc_pkg::OP_QIO_WORD: next_dc = fc_pkg::DUMMY_WORD;
          default: next_dc = fc_pkg::DUMMY_OCT;
        endcase
        next_ph = (next_dc == 4'h0) ? fc_pkg::PH_DATA : fc_pkg::PH_DUMMY;
      end
      default: next_ph = ph_e;
    endcase
  end

  // Frame flag: cleared the moment select rises
  always_ff @(posedge sclk or negedge arst_n or posedge cs_n) begin
    if (!arst_n || cs_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // Decode registers stay put after select rises; the system side reads them then
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      phase  <= fc_pkg::PH_OPC;
      op     <= 8'h00;
      op_ok  <= 1'b0;
      sh     <= 8'h00;
      bcnt   <= 3'h0;
      nbytes <= 3'h0;
      dcnt   <= 4'h0;
      addr   <= 24'h000000;
    end else begin
      sh   <= next_sh;
      bcnt <= next_cnt;
      if (!in_frame) begin
        op_ok  <= 1'b0;
        nbytes <= 3'h0;
      end else if (byte_done && ph_e != fc_pkg::PH_OPC && nbytes != 3'h7) begin
        nbytes <= nbytes + 3'h1;
      end
      if (ph_e == fc_pkg::PH_DUMMY) begin
        dcnt  <= dcnt - 4'h1;
        phase <= (dcnt == 4'h1) ? fc_pkg::PH_DATA : fc_pkg::PH_DUMMY;
      end else if (byte_done) begin
        phase <= next_ph;
        dcnt  <= next_dc;
      end else begin
        phase <= ph_e;
      end
      if (byte_done && ph_e == fc_pkg::PH_OPC) begin
        op    <= next_sh;
        op_ok <= 1'b1;
      end
      if (byte_done && ph_e == fc_pkg::PH_ADDR) begin
        addr <= {addr[15:0], next_sh};
      end
    end
  end

  // Written bytes, mode switch and reset pairing on the link side
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      quad    <= 1'b0;
      armed_l <= 1'b0;
      pd_tog  <= 1'b0;
      wb      <= '{default: 8'h00};
      pd      <= '{default: 8'h00};
      busy_l  <= 2'h0;
      stat_l1 <= 24'h000000;
      stat_l2 <= 24'h000000;
      rd_s1   <= 8'h00;
      rd_s2   <= 8'h00;
    end else begin
      busy_l  <= {busy_l[0], array_busy};
      stat_l1 <= {status_byte_three, status_byte_two, status_byte_one};
      stat_l2 <= stat_l1;
      rd_s1   <= rd_data;
      rd_s2   <= rd_s1;
      if (byte_done && ph_e == fc_pkg::PH_OPC && (!busy_l[1] || quad)) begin
        armed_l <= next_sh == fc_pkg::OP_RST_EN;
        if (next_sh == fc_pkg::OP_FOUR_ON && !busy_l[1]) begin
          quad <= 1'b1;
        end else if (next_sh == fc_pkg::OP_FOUR_OFF
                     || (next_sh == fc_pkg::OP_RST_DO && armed_l)) begin
          quad <= 1'b0;
        end
      end
      if (byte_done && ph_e == fc_pkg::PH_DATA && !rd_op) begin
        if (nbytes < 3'h4) begin
          wb[nbytes[1:0]] <= next_sh;
        end
        if (op inside {fc_pkg::OP_PROG, fc_pkg::OP_QPROG}) begin
          pd[~pd_tog] <= next_sh;
          pd_tog      <= ~pd_tog;
        end
      end
    end
  end

  // Read output on the falling edge, MSB first
  always_comb begin
    case (stat_sel)
      2'h1: src = stat_l2[7:0];
      2'h2: src = stat_l2[15:8];
      2'h3: src = stat_l2[23:16];
      default: src = rd_s2;
    endcase
    cur = (opos == 3'h0) ? src : osh;
  end

  always_ff @(negedge sclk or negedge arst_n or posedge cs_n) begin
    if (!arst_n || cs_n) begin
      io_out  <= 4'h0;
      io_oe   <= 4'h0;
      osh     <= 8'h00;
      opos    <= 3'h0;
      rcnt    <= 24'h000000;
      rd_addr <= 24'h000000;
    end else if (in_frame && phase == fc_pkg::PH_DATA && rd_op) begin
      case (ow)
        3'h4: begin
          io_out <= cur[7:4];
          io_oe  <= 4'hF;
        end
        3'h2: begin
          io_out <= {2'h0, cur[7], cur[6]};
          io_oe  <= 4'h3;
        end
        default: begin
          io_out <= {2'h0, cur[7], 1'b0};
          io_oe  <= 4'h2;
        end
      endcase
      osh  <= cur << ow;
      opos <= opos + ow;
      if (opos + ow == 3'h0) begin
        rcnt <= rcnt + 24'h1;
      end
      rd_addr <= addr + rcnt;
    end else begin
      io_oe   <= 4'h0;
      rd_addr <= addr;
    end
  end

  // ----------------------------------------------------------------
  // System domain: command execution at frame end
  // ----------------------------------------------------------------
  logic [2:0] cs_s, tog_s;
  logic [1:0] busy_s, quad_s;
  logic [7:0] sb1, sb2, sb3;
  logic       wel, vol_en, sus, armed, end_ev, good, allow, wr_ok;

  always_comb begin
    status_byte_one   = {sb1[7:2], wel, busy_s[1]};
    status_byte_two   = {sus, sb2[6:0]};
    status_byte_three = sb3;
    end_ev = cs_s[1] && !cs_s[2];
    good   = op_ok && bcnt == 3'h0;
    allow  = !busy_s[1] || op == fc_pkg::OP_SUSPEND;
    wr_ok  = wel || vol_en;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_s   <= 3'h7;
      tog_s  <= 3'h0;
      busy_s <= 2'h0;
      quad_s <= 2'h0;
    end else if (ce) begin
      cs_s   <= {cs_s[1:0], cs_n};
      tog_s  <= {tog_s[1:0], pd_tog};
      busy_s <= {busy_s[0], array_busy};
      quad_s <= {quad_s[0], quad};
    end
  end

  // Program data leaves as each byte completes; cmd_valid commits it later
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_valid <= 1'b0;
      data_byte  <= 8'h00;
      four_line_command_mode <= 1'b0;
    end else if (ce) begin
      data_valid <= tog_s[2] != tog_s[1];
      four_line_command_mode <= quad_s[1];
      if (tog_s[2] != tog_s[1]) begin
        data_byte <= pd[tog_s[1]];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sb1 <= fc_pkg::STAT_RST;
      sb2 <= fc_pkg::STAT_RST;
      sb3 <= fc_pkg::STAT_RST;
      wel <= 1'b0;
      vol_en <= 1'b0;
      sus <= 1'b0;
      armed <= 1'b0;
      wrap_cfg <= fc_pkg::WRAP_RST;
      cmd_valid <= 1'b0;
      cmd_op <= 8'h00;
      cmd_addr <= 24'h000000;
      dev_reset <= 1'b0;
    end else if (ce) begin
      cmd_valid <= 1'b0;
      dev_reset <= 1'b0;
      if (end_ev && good && allow) begin
        armed    <= op == fc_pkg::OP_RST_EN;
        case (op)
          fc_pkg::OP_WR_EN: wel <= 1'b1;
          fc_pkg::OP_VOL_EN: vol_en <= 1'b1;
          fc_pkg::OP_WR_DIS: begin
            wel    <= 1'b0;
            vol_en <= 1'b0;
          end
          fc_pkg::OP_STAT_WR1, fc_pkg::OP_STAT_WR2, fc_pkg::OP_STAT_WR3: begin
            if (wr_ok && nbytes != 3'h0) begin
              if (op == fc_pkg::OP_STAT_WR1) begin
                sb1 <= wb[0];
                if (nbytes > 3'h1) sb2 <= wb[1];
                if (nbytes > 3'h2) sb3 <= wb[2];
              end else if (op == fc_pkg::OP_STAT_WR2) begin
                sb2 <= wb[0];
              end else begin
                sb3 <= wb[0];
              end
              wel    <= 1'b0;
              vol_en <= 1'b0;
            end
          end
          fc_pkg::OP_WRAP_SET: begin
            if (nbytes > fc_pkg::WRAP_BYTE) begin
              wrap_cfg <= wb[fc_pkg::WRAP_BYTE[1:0]][fc_pkg::WRAP_MSB:fc_pkg::WRAP_LSB];
            end
          end
          fc_pkg::OP_PROG, fc_pkg::OP_QPROG, fc_pkg::OP_ERASE_4K, fc_pkg::OP_ERASE_32K,
          fc_pkg::OP_ERASE_64K, fc_pkg::OP_CHIP_ER, fc_pkg::OP_CHIP_ER2: begin
            if (wel && (op inside {fc_pkg::OP_CHIP_ER, fc_pkg::OP_CHIP_ER2}
                        ? nbytes == 3'h0
                        : (op inside {fc_pkg::OP_PROG, fc_pkg::OP_QPROG}
                           ? nbytes > fc_pkg::ADDR_BYTES
                           : nbytes == fc_pkg::ADDR_BYTES))) begin
              cmd_valid <= 1'b1;
              cmd_op    <= op;
              cmd_addr  <= addr;
              wel       <= 1'b0;
            end
          end
          fc_pkg::OP_SUSPEND: begin
            if (busy_s[1] && !sus) begin
              sus       <= 1'b1;
              cmd_valid <= 1'b1;
              cmd_op    <= op;
            end
          end
          fc_pkg::OP_RESUME: begin
            if (sus) begin
              sus       <= 1'b0;
              cmd_valid <= 1'b1;
              cmd_op    <= op;
            end
          end
          fc_pkg::OP_RST_DO: begin
            if (armed) begin
              dev_reset <= 1'b1;
              wel       <= 1'b0;
              vol_en    <= 1'b0;
              sus       <= 1'b0;
              wrap_cfg  <= fc_pkg::WRAP_RST;
            end
          end
          default: cmd_valid <= 1'b0;
        endcase
      end
    end
  end
endmodule

// ---- sim/flash_cmd_decoder_chk.sv ----
// Port checker for the serial flash command decoder
module flash_cmd_decoder_chk (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       cs_n,
  input wire logic [3:0] io_oe,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic       data_valid,
  input wire logic [2:0] wrap_cfg,
  input wire logic       four_line_command_mode,
  input wire logic       dev_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_cmd_pulse_one: assert property (cmd_valid |=> !cmd_valid)
    else $error("cmd pulse too long");
  a_rst_pulse_one: assert property (dev_reset |=> !dev_reset)
    else $error("reset pulse too long");
  a_data_pulse_one: assert property (data_valid |=> !data_valid)
    else $error("data pulse too long");
  a_cmd_after_close: assert property (cmd_valid |-> $past(cs_n, 2))
    else $error("command before select rose");
  a_oe_idle_off: assert property (cs_n |-> io_oe == 4'h0)
    else $error("lines driven while deselected");
  a_oe_legal_set: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("odd enable pattern");
  a_quad_oe_all: assert property (!cs_n && four_line_command_mode
    |-> io_oe inside {4'h0, 4'hF}) else $error("partial drive in four-line mode");
  a_op_legal_set: assert property (cmd_valid |-> cmd_op inside {8'h02, 8'h32, 8'h20,
    8'h52, 8'hD8, 8'hC7, 8'h60, 8'h75, 8'h7A}) else $error("bad committed opcode");
  a_op_with_cmd: assert property ($changed(cmd_op) |-> cmd_valid)
    else $error("opcode moved without commit");
  a_wrap_at_close: assert property ($changed(wrap_cfg) |-> $past(cs_n, 2))
    else $error("wrap moved inside frame");
  c_cmd: cover property (cmd_valid);
  c_data: cover property (data_valid);
  c_rst: cover property (dev_reset);
  c_quad: cover property ($rose(four_line_command_mode));
endmodule

bind flash_cmd_decoder flash_cmd_decoder_chk i_flash_cmd_decoder_chk (
  .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .io_oe(io_oe), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .data_valid(data_valid), .wrap_cfg(wrap_cfg),
  .four_line_command_mode(four_line_command_mode), .dev_reset(dev_reset));

// ---- sim/flash_host.sv ----
// Host controller model driving the serial link of the flash decoder
module flash_host (
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      drv,
  input  wire logic [3:0] io_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv  = 4'hF;
  end
  // Lines change after the fall and hold over the rise
  task automatic shift(input logic [3:0] v, output logic [3:0] r);
    drv = v;
    #3 sclk = 1'b1;
    r = io_in;
    #3 sclk = 1'b0;
  endtask
  task automatic begin_frame();
    cs_n = 1'b0;
    #4;
  endtask
  // Whole bytes only; frames that end mid-byte add bits with shift
  task automatic send(input logic [7:0] b, input int lanes);
    logic [3:0] r;
    repeat (8 / lanes) begin
      shift(lanes == 4 ? b[7:4] : {3'h7, b[7]}, r);
      b = lanes == 4 ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
    end
  endtask
  // Released lines show a changing pattern, never a held value
  task automatic recv(input int lanes, output logic [7:0] b);
    logic [3:0] r;
    repeat (8 / lanes) begin
      shift(~drv, r);
      b = lanes == 1 ? {b[6:0], r[1]} : lanes == 2 ? {b[5:0], r[1:0]} : {b[3:0], r};
    end
  endtask
  task automatic end_frame();
    #2 cs_n = 1'b1;
    drv = ~drv;
    #60;
  endtask
endmodule

// ---- sim/flash_cmd_decoder_tb_top.sv ----
// Self-checking bench for the serial flash command decoder
module flash_cmd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        array_busy = 1'b0;
  logic [7:0]  rd_data = 8'hC3;
  logic        sclk, cs_n, cmd_valid, data_valid, four_line_command_mode, dev_reset;
  logic [3:0]  io_in, io_out, io_oe, drv, r;
  logic [7:0]  cmd_op, data_byte, last_data, b;
  logic [23:0] cmd_addr;
  logic [2:0]  wrap_cfg;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          n_cmd = 0;
  int          n_rst = 0;
  int          n0;
  always #2.5 clk = ~clk;
  assign io_in = (io_oe & io_out) | (~io_oe & drv);
  flash_cmd_decoder i_flash_cmd_decoder (
    .clk(clk), .arst_n(arst_n), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .array_busy(array_busy), .rd_data(rd_data),
    .rd_addr(), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .data_valid(data_valid), .data_byte(data_byte), .wrap_cfg(wrap_cfg),
    .four_line_command_mode(four_line_command_mode), .dev_reset(dev_reset));
  flash_host i_flash_host (.sclk(sclk), .cs_n(cs_n), .drv(drv), .io_in(io_in));
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (dev_reset === 1'b1) n_rst <= n_rst + 1;
    if (data_valid === 1'b1) last_data <= data_byte;
  end
  // ------
  // Helpers
  // ------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Bytes are right-aligned, first byte highest
  task automatic frame(input logic [39:0] v, input int n, input int lanes);
    i_flash_host.begin_frame();
    for (int i = 0; i < n; i++) i_flash_host.send(v[8*(n-1-i) +: 8], lanes);
    i_flash_host.end_frame();
  endtask
  task automatic stat(input logic [7:0] op, input int lanes, input logic [7:0] exp);
    logic [7:0] b1, b2;
    i_flash_host.begin_frame();
    i_flash_host.send(op, lanes);
    i_flash_host.recv(lanes, b1);
    i_flash_host.recv(lanes, b2);
    i_flash_host.end_frame();
    chk(b1, exp);
    chk(b2, exp);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_status();
    stat(8'h05, 1, 8'h00);
    frame(40'h06, 1, 1);
    stat(8'h05, 1, 8'h02);
    frame(40'h01FC4221, 4, 1);
    stat(8'h05, 1, 8'hFC);
    stat(8'h35, 1, 8'h42);
    stat(8'h15, 1, 8'h21);
    frame(40'h50, 1, 1);
    frame(40'h3103, 2, 1);
    stat(8'h35, 1, 8'h03);
    frame(40'h06, 1, 1);
    frame(40'h1105, 2, 1);
    stat(8'h33, 1, 8'h05);
    frame(40'h06, 1, 1);
    frame(40'h04, 1, 1);
    frame(40'h0100, 2, 1);
    stat(8'h05, 1, 8'hFC);
    $display("test status done, mismatches %0d", error_cnt);
  endtask
  task automatic t_prog();
    frame(40'h06, 1, 1);
    frame(40'h02123456A5, 5, 1);
    chk(cmd_op, 8'h02);
    chk(cmd_addr, 24'h123456);
    chk(last_data, 8'hA5);
    frame(40'h06, 1, 1);
    i_flash_host.begin_frame();
    for (int i = 0; i < 4; i++) i_flash_host.send(8'(32'h32654321 >> (24 - 8 * i)), 1);
    i_flash_host.send(8'h3C, 4);
    i_flash_host.end_frame();
    chk(cmd_op, 8'h32);
    chk(cmd_addr, 24'h654321);
    chk(last_data, 8'h3C);
    stat(8'h05, 1, 8'hFC);
    $display("test program done, mismatches %0d", error_cnt);
  endtask
  task automatic t_erase();
    logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    frame(40'h06, 1, 1);
    n0 = n_cmd;
    i_flash_host.begin_frame();
    i_flash_host.send(8'h20, 1);
    repeat (19) i_flash_host.shift(4'h7, r);
    i_flash_host.end_frame();
    chk(n_cmd, n0);
    for (int i = 0; i < 5; i++) begin
      frame(40'h06, 1, 1);
      frame({ops[i], 32'h0ABCDE00} >> (i < 3 ? 8 : 32), i < 3 ? 4 : 1, 1);
      chk(cmd_op, ops[i]);
      chk(n_cmd, n0 + i + 1);
      if (i < 3) chk(cmd_addr, 24'h0ABCDE);
    end
    $display("test erase done, mismatches %0d", error_cnt);
  endtask
  task automatic t_busy();
    @(negedge clk) array_busy = 1'b1;
    repeat (6) @(negedge clk);
    frame(40'h06, 1, 1);
    stat(8'h05, 1, 8'hFD);
    frame(40'h75, 1, 1);
    chk(cmd_op, 8'h75);
    n0 = n_cmd;
    frame(40'h06, 1, 1);
    frame(40'hD8000000, 4, 1);
    chk(n_cmd, n0);
    stat(8'h35, 1, 8'h83);
    @(negedge clk) array_busy = 1'b0;
    repeat (6) @(negedge clk);
    frame(40'h7A, 1, 1);
    chk(cmd_op, 8'h7A);
    chk(n_cmd, n0 + 1);
    $display("test busy done, mismatches %0d", error_cnt);
  endtask
  task automatic t_mode();
    frame(40'h7700000F5F, 5, 1);
    chk(wrap_cfg, 3'h5);
    frame(40'h77FFFFFFA0, 5, 1);
    chk(wrap_cfg, 3'h2);
    frame(40'h38, 1, 1);
    chk(four_line_command_mode, 1'b1);
    frame(40'h06, 1, 4);
    stat(8'h05, 4, 8'hFE);
    frame(40'h04, 1, 4);
    frame(40'hFF, 1, 4);
    chk(four_line_command_mode, 1'b0);
    $display("test wrap and mode done, mismatches %0d", error_cnt);
  endtask
  task automatic t_read();
    logic [7:0] ops[4] = '{8'h03, 8'h0B, 8'h3B, 8'h6B};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) rd_data = 8'h5A + 8'(i);
      i_flash_host.begin_frame();
      for (int k = 0; k < 4; k++) i_flash_host.send(k == 0 ? ops[i] : 8'h40, 1);
      if (i > 0) i_flash_host.send(8'h00, 1);
      i_flash_host.recv(i == 3 ? 4 : i == 2 ? 2 : 1, b);
      if (i == 0) repeat (3) i_flash_host.shift(4'h7, r);
      i_flash_host.end_frame();
      chk(b, 8'h5A + 8'(i));
    end
    stat(8'h05, 1, 8'hFC);
    $display("test read done, mismatches %0d", error_cnt);
  endtask
  // Address ends in 50h, so word and octal alignment both hold
  task automatic t_qio();
    logic [7:0] ops[3] = '{8'hEB, 8'hE7, 8'hE3};
    int         dum[3] = '{4, 2, 0};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk) rd_data = 8'hA1 + 8'(i);
      i_flash_host.begin_frame();
      i_flash_host.send(ops[i], 1);
      i_flash_host.send(8'h12, 4);
      i_flash_host.send(8'h34, 4);
      i_flash_host.send(8'h50, 4);
      i_flash_host.send(8'hFF, 4);
      repeat (dum[i]) i_flash_host.shift(4'hF, r);
      i_flash_host.recv(4, b);
      i_flash_host.end_frame();
      chk(b, 8'hA1 + 8'(i));
    end
    $display("test quad io done, mismatches %0d", error_cnt);
  endtask
  task automatic t_reset();
    n0 = n_rst;
    frame(40'h66, 1, 1);
    frame(40'h04, 1, 1);
    frame(40'h99, 1, 1);
    chk(n_rst, n0);
    frame(40'h66, 1, 1);
    frame(40'h99, 1, 1);
    chk(n_rst, n0 + 1);
    $display("test reset done, mismatches %0d", error_cnt);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    #40;
    t_status();
    t_prog();
    t_erase();
    t_busy();
    t_mode();
    t_read();
    t_qio();
    t_reset();
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
